// *** hdl/mw_regs.svh ***
// Behaviour
// RULE1: each instruction opens with a start bit of one while chip select is high
// RULE2: opcode 00 uses two top address bits: disable, enable, erase all, write all
// RULE3: write-all carries data, 22 or 29 clocks total, pattern lands everywhere
// RULE4: opcodes 01 write, 10 read, 11 erase; x8 uses ignored bit plus 10 bits
// RULE5: x16 addressed commands use ignored bit plus 9-bit address, 16 data bits
// RULE6: host gives exactly 14 or 13 clocks without data, more with data
// RULE7: don't-care address positions never change the decoded operation
// RULE8: organization input high or open selects x16, low selects x8
// RULE9: erase-all sets every array bit to one
// RULE10: programming commands need write enable; disable command or power-up clears it
// RULE11: programming starts at chip select fall; raised select shows busy zero, ready one
// RULE12: host waits for ready before the next instruction
// RULE13: read shifts out a leading zero then the word, changing on rising clocks
// RULE14: read pointer advances after each word while select stays high
// RULE15: power-on reset active ignores all serial activity
// RULE16: power-on reset release clears state and write enable, waits in standby
// RULE17: power-on reset reasserted abandons any decode in progress
// RULE18: standby entered with select low only when no programming remains
// RULE19: data out released when select low and nothing is presented
// RULE20: bit counter and shift register cleared whenever select is low
`ifndef MW_REGS_SVH
`define MW_REGS_SVH
`define OP_SUB 2'h0
`define OP_WRITE 2'h1
`define OP_READ 2'h2
`define OP_ERASE 2'h3
`define SUB_PROGRAM_DISABLE_CMD 2'h0
`define SUB_WRITE_WHOLE_ARRAY_CMD 2'h1
`define SUB_ERASE_WHOLE_ARRAY_CMD 2'h2
`define SUB_PROGRAM_ENABLE_CMD 2'h3
`define OPCODE_BITS 5'h02
`define SUB_END 5'h04
`define ADDR_BITS_X8 5'h0B
`define ADDR_BITS_X16 5'h0A
`define DATA_BITS_X8 5'h08
`define DATA_BITS_X16 5'h10
`define ADDR_MASK_X8 10'h3FF
`define ADDR_MASK_X16 10'h1FF
`define ERASED_WORD 16'hFFFF
`define ERASED_BYTE 8'hFF
`define LAST_WORD 9'h1FF
`define WORDS 32'h0000_0200
`define FIFO_DEPTH 32'h0000_0010
`define TWP_US 32'h0000_1388
`define CLK_MHZ 32'h0000_00FA
`define TWP_CYCLES (`TWP_US * `CLK_MHZ)
`endif

// *** hdl/mw_pkg.sv ***
`default_nettype none
package mw_pkg;
  typedef enum logic [3:0] {
    FR_HUNT = 4'h1,
    FR_BITS = 4'h2,
    FR_READ = 4'h4,
    FR_DONE = 4'h8
  } frame_t;
  typedef enum logic [2:0] {
    ENG_IDLE = 3'h1,
    ENG_WAIT = 3'h2,
    ENG_SWEEP = 3'h4
  } eng_t;
  typedef enum logic [3:0] {
    PEND_WRITE = 4'h1,
    PEND_ERASE = 4'h2,
    PEND_FILL_ALL = 4'h4,
    PEND_CLEAR_ALL = 4'h8
  } pend_t;
endpackage
`default_nettype wire

// *** hdl/sync_fifo.sv ***
`timescale 1ns/100ps
`default_nettype none
module sync_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic clear,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] store [0:DEPTH-1];
  logic [AW-1:0] wrPtr;
  logic [AW-1:0] rdPtr;
  logic [AW:0] count;
  logic push;
  logic pop;
  assign inReady = (count != (AW+1)'(DEPTH));
  assign outValid = (count != '0);
  assign outData = store[rdPtr];
  assign push = ce && inValid && inReady;
  assign pop = ce && outValid && outReady;
  always_ff @(posedge clk) begin
    if (push) begin
      store[wrPtr] <= inData;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_b || (ce && clear)) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wrPtr <= (wrPtr == AW'(DEPTH - 1)) ? '0 : wrPtr + 1'b1;
      end
      if (pop) begin
        rdPtr <= (rdPtr == AW'(DEPTH - 1)) ? '0 : rdPtr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end
  fifoCount_a: assert property (@(posedge clk) disable iff (!rst_b || clear)
    (push && !pop) |=> count == $past(count) + 1'b1)
    else $error("fifo count did not grow on push");
  fifoBounds_a: assert property (@(posedge clk) disable iff (!rst_b)
    count <= (AW+1)'(DEPTH))
    else $error("fifo count above depth");
endmodule
`default_nettype wire

// *** hdl/microwire_eeprom_instruction_decoder.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "mw_regs.svh"
module microwire_eeprom_instruction_decoder
  import mw_pkg::*;
#(
  parameter int TWP_CYCLES = `TWP_CYCLES,
  parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic powerOnReset,
  input wire logic chipSelect,
  input wire logic serial_clock,
  input wire logic dataIn,
  input wire logic organization_select,
  output logic dataOut,
  output logic dataOutEn,
  output logic busy,
  output logic writeEnable,
  output logic standby
);
  localparam int TIMER_W = $clog2(TWP_CYCLES + 1);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [4:0] addrLen(input logic wide);
    return wide ? `ADDR_BITS_X16 : `ADDR_BITS_X8;
  endfunction
  function automatic logic [4:0] dataLen(input logic wide);
    return wide ? `DATA_BITS_X16 : `DATA_BITS_X8;
  endfunction
  function automatic logic [9:0] addrMask(input logic wide);
    return wide ? `ADDR_MASK_X16 : `ADDR_MASK_X8;
  endfunction
  function automatic logic [8:0] wordIndex(input logic [9:0] a, input logic wide);
    return wide ? a[8:0] : a[9:1];
  endfunction
  function automatic logic [9:0] nextPtr(input logic [9:0] a, input logic wide);
    return (a + 10'h001) & addrMask(wide);
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] csPipe;
  logic [1:0] sclkPipe;
  logic [1:0] dinPipe;
  logic [1:0] widthPipe;
  logic [1:0] porPipe;
  logic sclkPrev;
  logic csPrev;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      csPipe <= 2'h0;
      sclkPipe <= 2'h0;
      dinPipe <= 2'h0;
      widthPipe <= 2'h3;
      porPipe <= 2'h3;
      sclkPrev <= 1'b0;
      csPrev <= 1'b0;
    end else if (ce) begin
      csPipe <= {csPipe[0], chipSelect};
      sclkPipe <= {sclkPipe[0], serial_clock};
      dinPipe <= {dinPipe[0], dataIn};
      widthPipe <= {widthPipe[0], organization_select};
      porPipe <= {porPipe[0], powerOnReset};
      sclkPrev <= sclkPipe[1];
      csPrev <= csPipe[1];
    end
  end
  logic csS;
  logic dinS;
  logic x16;
  logic porS;
  logic sclkRise;
  logic csRise;
  logic csFall;
  assign csS = csPipe[1];
  assign dinS = dinPipe[1];
  assign x16 = widthPipe[1]; // see RULE8
  assign porS = porPipe[1];
  assign sclkRise = ce && !porS && csS && sclkPipe[1] && !sclkPrev; // see RULE15
  assign csRise = ce && csS && !csPrev;
  assign csFall = ce && !csS && csPrev;

  // ----------------------------------------------------------------
  // instruction decode
  // ----------------------------------------------------------------
  frame_t frame;
  logic [4:0] bitCount;
  logic [27:0] shiftIn;
  logic [1:0] opcode;
  logic [1:0] subCmd;
  logic [9:0] addr;
  logic [15:0] wdata;
  logic armed;
  pend_t pendOp;
  logic [27:0] next_shift;
  logic [4:0] next_count;
  logic [4:0] opEnd;
  logic [4:0] dataEnd;
  logic bitTaken;
  logic addrDone;
  logic dataDone;
  logic readStart;
  logic subDone;
  assign next_shift = {shiftIn[26:0], dinS};
  assign next_count = bitCount + 5'h01;
  assign opEnd = `OPCODE_BITS + addrLen(x16); // see RULE4 see RULE5
  assign dataEnd = opEnd + dataLen(x16); // see RULE3
  assign bitTaken = sclkRise && frame == FR_BITS;
  assign addrDone = bitTaken && next_count == opEnd; // see RULE6
  assign dataDone = bitTaken && next_count == dataEnd;
  assign readStart = addrDone && opcode == `OP_READ;
  assign subDone = addrDone && opcode == `OP_SUB;

  always_ff @(posedge clk) begin
    if (!rst_b || porS) begin // see RULE16 see RULE17
      frame <= FR_HUNT;
      bitCount <= 5'h00;
      shiftIn <= 28'h0000000;
      opcode <= 2'h0;
      subCmd <= 2'h0;
      addr <= 10'h000;
      wdata <= 16'h0000;
      armed <= 1'b0;
      pendOp <= PEND_WRITE;
    end else if (ce) begin
      if (!csS) begin // see RULE20
        frame <= FR_HUNT;
        bitCount <= 5'h00;
        shiftIn <= 28'h0000000;
        if (!csPrev) begin
          armed <= 1'b0;
        end
      end else if (sclkRise) begin
        case (frame)
          FR_HUNT: begin
            if (dinS && !busy) begin // see RULE1 see RULE12
              frame <= FR_BITS;
            end
          end
          FR_BITS: begin
            shiftIn <= next_shift;
            bitCount <= next_count;
            if (next_count == `OPCODE_BITS) begin
              opcode <= next_shift[1:0];
            end
            if (next_count == `SUB_END) begin
              subCmd <= next_shift[1:0]; // see RULE2
            end
            if (next_count == opEnd) begin
              addr <= next_shift[9:0] & addrMask(x16); // see RULE7
              frame <= FR_DONE;
              case (opcode)
                `OP_READ: frame <= FR_READ;
                `OP_WRITE: frame <= FR_BITS;
                `OP_ERASE: begin
                  armed <= 1'b1;
                  pendOp <= PEND_ERASE;
                end
                default: begin
                  if (subCmd == `SUB_ERASE_WHOLE_ARRAY_CMD) begin // see RULE2
                    armed <= 1'b1;
                    pendOp <= PEND_CLEAR_ALL;
                  end else if (subCmd == `SUB_WRITE_WHOLE_ARRAY_CMD) begin
                    frame <= FR_BITS;
                  end
                end
              endcase
            end
            if (next_count == dataEnd) begin
              wdata <= x16 ? next_shift[15:0] : {8'h00, next_shift[7:0]};
              armed <= 1'b1;
              pendOp <= (opcode == `OP_WRITE) ? PEND_WRITE : PEND_FILL_ALL; // see RULE3
              frame <= FR_DONE;
            end
          end
          FR_DONE: armed <= 1'b0; // surplus clocks cancel an armed programming command
          FR_READ: frame <= FR_READ;
          default: frame <= FR_HUNT;
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b || porS) begin
      writeEnable <= 1'b0; // see RULE16
    end else if (subDone) begin
      if (subCmd == `SUB_PROGRAM_ENABLE_CMD) begin
        writeEnable <= 1'b1; // see RULE10
      end else if (subCmd == `SUB_PROGRAM_DISABLE_CMD) begin
        writeEnable <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // programming engine and array
  // ----------------------------------------------------------------
  logic [15:0] mem [0:`WORDS-1];
  eng_t engState;
  logic [TIMER_W-1:0] timer;
  logic [8:0] sweepIdx;
  pend_t pOp;
  logic [9:0] pAddr;
  logic [15:0] pData;
  logic pWide;
  logic memWe;
  logic [8:0] memIdx;
  logic [15:0] memVal;
  logic [15:0] oldWord;
  logic [7:0] byteVal;
  logic isAll;
  assign isAll = (pOp == PEND_FILL_ALL) || (pOp == PEND_CLEAR_ALL);

  always_ff @(posedge clk) begin
    if (!rst_b || porS) begin
      engState <= ENG_IDLE;
      busy <= 1'b0;
      timer <= '0;
      sweepIdx <= 9'h000;
      pOp <= PEND_WRITE;
      pAddr <= 10'h000;
      pData <= 16'h0000;
      pWide <= 1'b1;
    end else if (ce) begin
      case (engState)
        ENG_IDLE: begin
          if (csFall && armed && writeEnable) begin // see RULE10 see RULE11
            engState <= ENG_WAIT;
            busy <= 1'b1;
            timer <= TIMER_W'(TWP_CYCLES - 1);
            pOp <= pendOp;
            pAddr <= addr;
            pData <= wdata;
            pWide <= x16;
          end
        end
        ENG_WAIT: begin
          if (timer == '0) begin
            sweepIdx <= 9'h000;
            engState <= isAll ? ENG_SWEEP : ENG_IDLE;
            busy <= isAll;
          end else begin
            timer <= timer - 1'b1;
          end
        end
        ENG_SWEEP: begin
          sweepIdx <= sweepIdx + 9'h001;
          if (sweepIdx == `LAST_WORD) begin
            engState <= ENG_IDLE;
            busy <= 1'b0;
          end
        end
        default: engState <= ENG_IDLE;
      endcase
    end
  end

  always_comb begin
    oldWord = mem[wordIndex(pAddr, pWide)];
    byteVal = (pOp == PEND_ERASE) ? `ERASED_BYTE : pData[7:0];
    memWe = 1'b0;
    memIdx = wordIndex(pAddr, pWide);
    memVal = 16'h0000;
    if (engState == ENG_WAIT && timer == '0 && !isAll) begin
      memWe = 1'b1;
      if (pWide) begin
        memVal = (pOp == PEND_ERASE) ? `ERASED_WORD : pData;
      end else begin
        memVal = pAddr[0] ? {byteVal, oldWord[7:0]} : {oldWord[15:8], byteVal};
      end
    end else if (engState == ENG_SWEEP) begin
      memWe = 1'b1;
      memIdx = sweepIdx;
      if (pOp == PEND_CLEAR_ALL) begin
        memVal = `ERASED_WORD; // see RULE9
      end else begin
        memVal = pWide ? pData : {pData[7:0], pData[7:0]}; // see RULE3
      end
    end
  end

  always_ff @(posedge clk) begin
    if (ce && rst_b && !porS && memWe) begin
      mem[memIdx] <= memVal;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b || porS) begin
      standby <= 1'b1;
    end else if (ce) begin
      standby <= !csS && engState == ENG_IDLE; // see RULE18
    end
  end

  // ----------------------------------------------------------------
  // read fetch into the buffer
  // ----------------------------------------------------------------
  logic fetching;
  logic [9:0] fetchPtr;
  logic fifoInReady;
  logic [15:0] fifoInData;
  logic fifoOutValid;
  logic fifoOutReady;
  logic [15:0] fifoOutData;
  logic [15:0] fetchWord;
  assign fetchWord = mem[wordIndex(fetchPtr, x16)];
  assign fifoInData = x16 ? fetchWord
                    : {(fetchPtr[0] ? fetchWord[15:8] : fetchWord[7:0]), 8'h00};

  always_ff @(posedge clk) begin
    if (!rst_b || porS) begin
      fetching <= 1'b0;
      fetchPtr <= 10'h000;
    end else if (ce) begin
      if (!csS) begin
        fetching <= 1'b0;
      end else if (readStart) begin
        fetching <= 1'b1;
        fetchPtr <= next_shift[9:0] & addrMask(x16);
      end else if (fetching && fifoInReady) begin
        fetchPtr <= nextPtr(fetchPtr, x16); // see RULE14
      end
    end
  end

  sync_fifo #(
    .WIDTH(16),
    .DEPTH(FIFO_DEPTH)
  ) readBuffer (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .clear(!csS || porS),
    .inValid(fetching),
    .inReady(fifoInReady),
    .inData(fifoInData),
    .outValid(fifoOutValid),
    .outReady(fifoOutReady),
    .outData(fifoOutData)
  );

  // ----------------------------------------------------------------
  // serial output and status
  // ----------------------------------------------------------------
  logic [15:0] outShift;
  logic [4:0] outLeft;
  logic statusMode;
  logic popWord;
  assign popWord = sclkRise && frame == FR_READ && outLeft == 5'h00;
  assign fifoOutReady = popWord;

  always_ff @(posedge clk) begin
    if (!rst_b || porS) begin
      dataOut <= 1'b0;
      dataOutEn <= 1'b0;
      statusMode <= 1'b0;
      outShift <= 16'h0000;
      outLeft <= 5'h00;
    end else if (ce) begin
      if (!csS) begin // see RULE19
        dataOut <= 1'b0;
        dataOutEn <= 1'b0;
        statusMode <= 1'b0;
        outLeft <= 5'h00;
      end else if (statusMode) begin
        dataOutEn <= 1'b1;
        dataOut <= !busy; // see RULE11
        if (sclkRise && dinS && !busy) begin
          statusMode <= 1'b0;
        end
      end else if (csRise && busy) begin
        statusMode <= 1'b1;
      end else if (readStart) begin
        dataOutEn <= 1'b1;
        dataOut <= 1'b0; // see RULE13
      end else if (popWord) begin
        dataOut <= fifoOutValid ? fifoOutData[15] : 1'b0;
        outShift <= fifoOutValid ? {fifoOutData[14:0], 1'b0} : 16'h0000;
        outLeft <= dataLen(x16) - 5'h01;
      end else if (sclkRise && frame == FR_READ) begin
        dataOut <= outShift[15]; // see RULE13
        outShift <= {outShift[14:0], 1'b0};
        outLeft <= outLeft - 5'h01;
      end else if (frame != FR_READ) begin
        dataOutEn <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  statusOut_a: assert property (@(posedge clk) disable iff (!rst_b || porS) // see RULE11
    (ce && csS && statusMode) |=> (dataOutEn && dataOut == !$past(busy)))
    else $error("status bit does not mirror busy");
  leadingZero_a: assert property (@(posedge clk) disable iff (!rst_b || porS) // see RULE13
    readStart |=> (dataOutEn && !dataOut))
    else $error("read did not start with a zero bit");
  wenGate_a: assert property (@(posedge clk) disable iff (!rst_b || porS) // see RULE10
    $rose(busy) |-> $past(writeEnable) && $past(csFall))
    else $error("programming started without enable or select fall");
  busyHold_a: assert property (@(posedge clk) disable iff (!rst_b || porS) // see RULE18
    $rose(busy) |-> busy[*8])
    else $error("busy dropped too early");
  porClear_a: assert property (@(posedge clk) disable iff (!rst_b) // see RULE16
    (ce && porS) |=> (!writeEnable && frame == FR_HUNT && !dataOutEn))
    else $error("power-on reset did not clear state");
  csLowClear_a: assert property (@(posedge clk) disable iff (!rst_b || porS) // see RULE20
    (ce && !csS) |=> (bitCount == 5'h00 && !dataOutEn && frame == FR_HUNT))
    else $error("select low did not clear decode");
  eraseAll_a: assert property (@(posedge clk) disable iff (!rst_b || porS) // see RULE9
    (ce && engState == ENG_SWEEP && pOp == PEND_CLEAR_ALL)
      |=> mem[$past(sweepIdx)] == `ERASED_WORD)
    else $error("erase-all left a word not all ones");
  addrAdvance_a: assert property (@(posedge clk) disable iff (!rst_b || porS) // see RULE14
    (ce && csS && fetching && fifoInReady && !readStart)
      |=> fetchPtr == nextPtr($past(fetchPtr), $past(x16)))
    else $error("read pointer did not advance");
endmodule
`default_nettype wire

// *** testbench/mw_host.sv ***
`timescale 1ns/100ps
`default_nettype none
module mw_host (
  input wire logic clk,
  input wire logic dataOut,
  input wire logic dataOutEn,
  output logic chipSelect,
  output logic serial_clock,
  output logic dataIn
);
  initial begin
    chipSelect = 1'b0;
    serial_clock = 1'b0;
    dataIn = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // released data line flips so a stale level is never seen
  task automatic stop();
    chipSelect <= 1'b0;
    dataIn <= ~dataIn;
    tick(6);
  endtask
  // n bits msb first, one serial clock each, start bit in b[n-1]
  task automatic send(input logic [31:0] b, input int n, input bit keep);
    chipSelect <= 1'b1;
    tick(5);
    for (int i = n - 1; i >= 0; i--) begin
      dataIn <= b[i];
      tick(5);
      serial_clock <= 1'b1;
      tick(5);
      serial_clock <= 1'b0;
    end
    tick(5);
    if (!keep) begin
      stop();
    end
  endtask
  task automatic rd(input int n, output logic [31:0] d, output logic lead, input bit keep);
    lead = dataOut;
    d = 32'h0000_0000;
    for (int i = 0; i < n; i++) begin
      serial_clock <= 1'b1;
      tick(5);
      serial_clock <= 1'b0;
      tick(5);
      d = {d[30:0], dataOut};
    end
    if (!keep) begin
      stop();
    end
  endtask
  // waits for ready before anything else is sent
  task automatic poll(output logic en, output logic first);
    chipSelect <= 1'b1;
    tick(8);
    en = dataOutEn;
    first = dataOut;
    for (int i = 0; i < 3000 && en === 1'b1 && dataOut !== 1'b1; i++) begin
      tick(1);
    end
    stop();
  endtask
endmodule
`default_nettype wire

// *** testbench/microwire_eeprom_instruction_decoder_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin numChecks++; if ((a) !== (e)) begin mismatches++; \
  $display("[ERR] %0t got %h want %h", $time, (a), (e)); end end
module microwire_eeprom_instruction_decoder_tb;
  logic clk, rst_b, ce, powerOnReset, organization_select, x16, en, first, lead;
  wire logic dataOut, dataOutEn, busy, writeEnable, standby, chipSelect, serial_clock, dataIn;
  logic [15:0] pat, d0, d1;
  logic [9:0] a;
  logic [31:0] got;
  logic [31:0] seed = 32'h0000_0062;
  int mismatches = 0, numChecks = 0, cycles = 0;
  microwire_eeprom_instruction_decoder #(.TWP_CYCLES(16), .FIFO_DEPTH(16)) DUT (.clk(clk),
    .rst_b(rst_b), .ce(ce), .powerOnReset(powerOnReset), .chipSelect(chipSelect),
    .serial_clock(serial_clock), .dataIn(dataIn), .organization_select(organization_select),
    .dataOut(dataOut), .dataOutEn(dataOutEn), .busy(busy), .writeEnable(writeEnable),
    .standby(standby));
  mw_host host (.clk(clk), .dataOut(dataOut), .dataOutEn(dataOutEn), .chipSelect(chipSelect),
    .serial_clock(serial_clock), .dataIn(dataIn));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      mismatches++;
      $display("[ERR] %0t timeout", $time);
      finishTest();
    end
  end
  // --------------------------------------------------------------
  // frame builders
  // --------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [31:0] frm(logic [1:0] op, logic [10:0] f);
    return x16 ? {19'h0, 1'b1, op, f[9:0]} : {18'h0, 1'b1, op, f};
  endfunction
  // don't care positions filled at random
  function automatic logic [10:0] sub(logic [1:0] s);
    logic [10:0] r;
    r = 11'(rnd());
    return x16 ? {1'b0, s, r[7:0]} : {s, r[8:0]};
  endfunction
  function automatic logic [10:0] adr(logic [9:0] w);
    logic [10:0] r;
    r = 11'(rnd());
    return x16 ? {1'b0, r[0], w[8:0]} : {r[0], w};
  endfunction
  task automatic put(logic [1:0] op, logic [10:0] f, logic [15:0] d, bit data);
    logic [31:0] b;
    int k;
    b = frm(op, f);
    k = x16 ? 13 : 14;
    if (data) begin
      b = x16 ? {b[15:0], d} : {b[23:0], d[7:0]};
      k = k + (x16 ? 16 : 8);
    end
    host.send(b, k, 1'b0);
  endtask
  task automatic prog(logic [1:0] op, logic [10:0] f, logic [15:0] d, bit data, logic on);
    put(op, f, d, data);
    `CHK({busy, standby}, {on, ~on})
    host.poll(en, first);
    `CHK(en, on)
    if (on) begin
      `CHK(first, 1'b0)
    end
    `CHK(standby, 1'b1)
  endtask
  task automatic rdChk(logic [9:0] w, logic [15:0] e0, logic [15:0] e1);
    host.send(frm(2'h2, adr(w)), x16 ? 13 : 14, 1'b1);
    host.rd(x16 ? 32 : 16, got, lead, 1'b0);
    `CHK(lead, 1'b0)
    `CHK(got, x16 ? {e0, e1} : {16'h0000, e0[7:0], e1[7:0]})
  endtask
  task automatic finishTest();
    $display("checks %0d mismatches %0d", numChecks, mismatches);
    if (mismatches == 0 && numChecks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial begin
    rst_b <= 1'b0;
    ce <= 1'b1;
    powerOnReset <= 1'b0;
    organization_select <= 1'b1;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    repeat (8) @(posedge clk);
    `CHK({writeEnable, standby}, 2'h1)
    `CHK(dataOutEn, 1'b0)
    $display("reset test done");
    for (int o = 1; o >= 0; o--) begin
      x16 = o[0];
      organization_select <= o[0];
      repeat (4) @(posedge clk);
      a = 10'(rnd()) & (x16 ? 10'h1FE : 10'h3FE);
      pat = 16'(rnd());
      d0 = 16'(rnd());
      d1 = 16'(rnd());
      prog(2'h1, adr(a), d0, 1'b1, 1'b0);
      put(2'h0, sub(2'h3), 16'h0000, 1'b0);
      `CHK(writeEnable, 1'b1)
      prog(2'h0, sub(2'h2), 16'h0000, 1'b0, 1'b1);
      rdChk(a, 16'hFFFF, 16'hFFFF);
      prog(2'h0, sub(2'h1), pat, 1'b1, 1'b1);
      rdChk(x16 ? 10'h1FF : 10'h3FF, pat, pat);
      prog(2'h1, adr(a), d0, 1'b1, 1'b1);
      prog(2'h1, adr(a + 10'h001), d1, 1'b1, 1'b1);
      rdChk(a, d0, d1);
      prog(2'h3, adr(a + 10'h001), 16'h0000, 1'b0, 1'b1);
      rdChk(a, d0, 16'hFFFF);
      put(2'h0, sub(2'h0), 16'h0000, 1'b0);
      `CHK(writeEnable, 1'b0)
      $display("organization %0d test done", o);
    end
    put(2'h0, sub(2'h3), 16'h0000, 1'b0);
    host.send(32'h0000_0028, 6, 1'b1);
    powerOnReset <= 1'b1;
    repeat (6) @(posedge clk);
    host.stop();
    `CHK(writeEnable, 1'b0)
    put(2'h0, sub(2'h3), 16'h0000, 1'b0);
    `CHK(writeEnable, 1'b0)
    powerOnReset <= 1'b0;
    repeat (8) @(posedge clk);
    `CHK(standby, 1'b1)
    put(2'h0, sub(2'h3), 16'h0000, 1'b0);
    `CHK(writeEnable, 1'b1)
    $display("power on reset test done");
    // byte stream longer than the prefetch buffer, x8 contents left by the last loop pass
    host.send(frm(2'h2, adr(a)), 14, 1'b1);
    for (int i = 0; i < 20; i++) begin
      host.rd(8, got, lead, 1'b1);
      `CHK(got[7:0], (i == 0) ? d0[7:0] : ((i == 1) ? 8'hFF : pat[7:0]))
    end
    `CHK(dataOutEn, 1'b1)
    host.stop();
    `CHK(dataOutEn, 1'b0)
    $display("stream read test done");
    finishTest();
  end
endmodule
`default_nettype wire
